// ===== src/exec_pkg.sv
// constants and types shared by the execution datapath and its register store
// assumes a 16-entry general register file of 16-bit words
package exec_pkg;
  localparam int unsigned WORD_W   = 16;
  localparam int unsigned REG_CNT  = 16;
  localparam int unsigned RD_PORTS = 4;
  localparam int unsigned WR_PORTS = 2;

  // instruction formats
  localparam logic [1:0] FMT_REG_TO_REG   = 2'h0;
  localparam logic [1:0] FMT_SHORT_MEMORY = 2'h1;
  localparam logic [1:0] FMT_IMMEDIATE    = 2'h2;
  localparam logic [1:0] FMT_INDEXED      = 2'h3;

  // opcodes (octal 17, 20..27, 30..33)
  localparam logic [5:0] OP_ROT_ZERO = 6'h0f;
  localparam logic [5:0] OP_SUB      = 6'h10;
  localparam logic [5:0] OP_SUB_DBL  = 6'h11;
  localparam logic [5:0] OP_ADD      = 6'h12;
  localparam logic [5:0] OP_ADD_DBL  = 6'h13;
  localparam logic [5:0] OP_CMP      = 6'h14;
  localparam logic [5:0] OP_CMP_DBL  = 6'h15;
  localparam logic [5:0] OP_MUL      = 6'h16;
  localparam logic [5:0] OP_DIV      = 6'h17;
  localparam logic [5:0] OP_AND      = 6'h18;
  localparam logic [5:0] OP_OR       = 6'h19;
  localparam logic [5:0] OP_XOR      = 6'h1a;
  localparam logic [5:0] OP_MASK_SUB = 6'h1b;

  // condition code layout
  localparam int unsigned CC_NONZERO_BIT  = 8;
  localparam int unsigned CC_NEGATIVE_BIT = 9;
  localparam logic [15:0] CC_RESET        = 16'h0000;

  // read port roles
  localparam int unsigned RP_ACC   = 0;
  localparam int unsigned RP_ACC1  = 1;
  localparam int unsigned RP_SRC   = 2;
  localparam int unsigned RP_SRC1  = 3;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_FETCH = 3'h2,
    ST_EXEC  = 3'h4
  } state_t;
endpackage

// ===== src/regfile_if.sv
// carrier between the datapath core and its general register store
// one clock domain; reads return one cycle after the address
`timescale 1ns/10ps
interface regfile_if;
  logic [exec_pkg::RD_PORTS-1:0][3:0]  raddr;
  logic [exec_pkg::RD_PORTS-1:0][15:0] rdata;
  logic [exec_pkg::WR_PORTS-1:0]       we;
  logic [exec_pkg::WR_PORTS-1:0][3:0]  waddr;
  logic [exec_pkg::WR_PORTS-1:0][15:0] wdata;
  modport core  (output raddr, output we, output waddr, output wdata, input rdata);
  modport store (input raddr, input we, input waddr, input wdata, output rdata);
endinterface

// ===== src/gen_reg_store.sv
// general register store: four registered read ports, two write ports
// assumes writer never relies on same-cycle read-after-write
`timescale 1ns/10ps
module gen_reg_store (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // access
  regfile_if.store  rf
);
  typedef struct packed {
    logic [exec_pkg::REG_CNT-1:0][15:0]  words;
    logic [exec_pkg::RD_PORTS-1:0][15:0] rdata;
  } store_t;

  store_t store_reg;
  store_t store_next;

  always_comb begin
    store_next = store_reg;
    for (int i = 0; i < exec_pkg::RD_PORTS; i++) begin
      store_next.rdata[i] = store_reg.words[rf.raddr[i]];
    end
    // port 1 wins a same-address collision: it carries the low half of pairs
    for (int w = 0; w < exec_pkg::WR_PORTS; w++) begin
      if (rf.we[w]) begin
        store_next.words[rf.waddr[w]] = rf.wdata[w];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      store_reg <= '0;
    end else begin
      store_reg <= store_next;
    end
  end

  assign rf.rdata = store_reg.rdata;
endmodule

// ===== src/arith_logic_exec_unit.sv
// arithmetic, logic, shift and masked-substitute execution datapath
// assumes decode logic supplies both memory words at Y and Y+1 with start
`timescale 1ns/10ps
// Overview of operation
// - immediate double circular shift rotates register pair left by operand bits 0-5.
// - indexed store-zeros writes an all-zero word to the effective address.
// - opcode 20 subtracts source from accumulator, writes back, sets condition code.
// - opcode 21 subtracts 32-bit source from accumulator pair; immediate form unassigned.
// - opcode 22 adds source to accumulator, writes back, sets condition code.
// - opcode 23 adds 32-bit source to accumulator pair; immediate form unassigned.
// - opcode 24 compares accumulator with source; only condition code changes.
// - opcode 25 compares 32-bit accumulator pair with 32-bit source.
// - opcode 26 multiplies source by second accumulator register into the pair.
// - divide remainder takes dividend sign and is smaller than divisor magnitude.
// - opcode 27 divides the pair; quotient to second, remainder to first.
// - opcode 30 bitwise AND into accumulator, sets condition code.
// - opcode 31 bitwise OR into accumulator, sets condition code.
// - opcode 32 bitwise exclusive OR into accumulator, sets condition code.
// - opcode 33 copies source bits under second-register mask into accumulator.
// - bit 8 means nonzero or unequal; bit 9 means negative or less.
module arith_logic_exec_unit (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // instruction request
  input  wire logic        start,
  input  wire logic [5:0]  opcode,
  input  wire logic [1:0]  format,
  input  wire logic [3:0]  acc_sel,
  input  wire logic [3:0]  src_sel,
  input  wire logic [15:0] operand_y,
  input  wire logic [15:0] mem_word_y,
  input  wire logic [15:0] mem_word_y1,
  // register preload and inspection while idle
  input  wire logic        load_en,
  input  wire logic [3:0]  load_sel,
  input  wire logic [15:0] load_data,
  input  wire logic [3:0]  peek_sel,
  output logic      [15:0] peek_data,
  // results
  output logic             done,
  output logic             illegal,
  output logic             mem_write_en,
  output logic      [15:0] mem_write_data,
  output logic      [15:0] cond_code
);
  typedef struct packed {
    exec_pkg::state_t st;
    logic [5:0]       op;
    logic [1:0]       fmt;
    logic [3:0]       a;
    logic [3:0]       m;
    logic [15:0]      y;
    logic [15:0]      mem0;
    logic [15:0]      mem1;
    logic [15:0]      cc;
    logic             done;
    logic             illegal;
    logic             mem_we;
    logic [15:0]      mem_wdata;
  } core_t;

  core_t core_reg;
  core_t core_next;
  regfile_if rf ();

  gen_reg_store u_store (
    .core_clk (core_clk),
    .rst      (rst),
    .rf       (rf.store)
  );

  logic [15:0] acc;
  logic [15:0] acc1;
  logic [15:0] src;
  logic [31:0] acc_dbl;
  logic [31:0] src_dbl;
  logic        is_exec;
  logic        bad;
  logic [31:0] res;
  logic        res_dbl;
  logic        cmp_op;
  logic        lt;
  logic [5:0]  rot_n;
  logic signed [31:0] dvd;
  logic signed [31:0] dvs;
  logic signed [31:0] quo;
  logic signed [31:0] rem;
  logic [31:0] prod;

  assign acc     = rf.rdata[exec_pkg::RP_ACC];
  assign acc1    = rf.rdata[exec_pkg::RP_ACC1];
  assign is_exec = (core_reg.st == exec_pkg::ST_EXEC);
  // high half first in pairs
  // pair ordering
  assign acc_dbl = {acc, acc1};
  assign src     = (core_reg.fmt == exec_pkg::FMT_REG_TO_REG) ? rf.rdata[exec_pkg::RP_SRC] :
                   (core_reg.fmt == exec_pkg::FMT_IMMEDIATE)  ? core_reg.y : core_reg.mem0;
  assign src_dbl = (core_reg.fmt == exec_pkg::FMT_REG_TO_REG) ?
                   {rf.rdata[exec_pkg::RP_SRC], rf.rdata[exec_pkg::RP_SRC1]} :
                   {core_reg.mem0, core_reg.mem1};
  assign rot_n   = (core_reg.fmt == exec_pkg::FMT_REG_TO_REG) ? src[5:0] : core_reg.y[5:0];

  // truncating divide
  // signed divide truncates toward zero, so the remainder follows the dividend
  assign dvd  = $signed(acc_dbl);
  assign dvs  = (src == 16'h0000) ? 32'sh00000001 : 32'($signed(src));
  assign quo  = dvd / dvs;
  assign rem  = dvd % dvs;
  // signed product
  // widen both factors first so the product keeps all 32 bits
  assign prod = 32'($signed(src)) * 32'($signed(acc1));

  always_comb begin
    core_next = core_reg;
    core_next.done   = 1'b0;
    core_next.illegal = 1'b0;
    core_next.mem_we = 1'b0;
    rf.raddr[exec_pkg::RP_ACC]  = core_reg.a;
    rf.raddr[exec_pkg::RP_ACC1] = 4'(core_reg.a + 4'h1);
    rf.raddr[exec_pkg::RP_SRC]  = core_reg.m;
    rf.raddr[exec_pkg::RP_SRC1] = 4'(core_reg.m + 4'h1);
    rf.we    = '0;
    rf.waddr[0] = core_reg.a;
    rf.waddr[1] = 4'(core_reg.a + 4'h1);
    rf.wdata = '0;
    bad      = 1'b0;
    res      = '0;
    res_dbl  = 1'b0;
    cmp_op   = 1'b0;
    lt       = 1'b0;
    case (core_reg.st)
      exec_pkg::ST_IDLE: begin
        rf.raddr[exec_pkg::RP_ACC] = peek_sel;
        rf.we[0]    = load_en;
        rf.waddr[0] = load_sel;
        rf.wdata[0] = load_data;
        if (start) begin
          core_next.st   = exec_pkg::ST_FETCH;
          core_next.op   = opcode;
          core_next.fmt  = format;
          core_next.a    = acc_sel;
          core_next.m    = src_sel;
          core_next.y    = operand_y;
          core_next.mem0 = mem_word_y;
          core_next.mem1 = mem_word_y1;
        end
      end
      exec_pkg::ST_FETCH: begin
        core_next.st = exec_pkg::ST_EXEC;
      end
      exec_pkg::ST_EXEC: begin
        core_next.st   = exec_pkg::ST_IDLE;
        core_next.done = 1'b1;
        case (core_reg.op)
          exec_pkg::OP_ROT_ZERO: begin
            if (core_reg.fmt == exec_pkg::FMT_REG_TO_REG ||
                core_reg.fmt == exec_pkg::FMT_IMMEDIATE) begin
              res     = 32'({acc_dbl, acc_dbl} >> (6'd32 - {1'b0, rot_n[4:0]}));
              res_dbl = 1'b1;
            end else begin
              core_next.mem_we    = 1'b1;
              core_next.mem_wdata = 16'h0000;
            end
          end
          exec_pkg::OP_SUB: res = {16'h0000, 16'(acc - src)};
          exec_pkg::OP_ADD: res = {16'h0000, 16'(acc + src)};
          exec_pkg::OP_SUB_DBL: begin
            res     = acc_dbl - src_dbl;
            res_dbl = 1'b1;
            bad     = (core_reg.fmt == exec_pkg::FMT_IMMEDIATE);
          end
          exec_pkg::OP_ADD_DBL: begin
            res     = acc_dbl + src_dbl;
            res_dbl = 1'b1;
            bad     = (core_reg.fmt == exec_pkg::FMT_IMMEDIATE);
          end
          exec_pkg::OP_CMP: begin
            cmp_op = 1'b1;
            res    = {16'h0000, acc ^ src};
            lt     = ($signed(acc) < $signed(src));
          end
          exec_pkg::OP_CMP_DBL: begin
            cmp_op = 1'b1;
            res    = acc_dbl ^ src_dbl;
            lt     = ($signed(acc_dbl) < $signed(src_dbl));
            bad    = (core_reg.fmt == exec_pkg::FMT_IMMEDIATE);
          end
          exec_pkg::OP_MUL: begin
            res     = prod;
            res_dbl = 1'b1;
          end
          exec_pkg::OP_DIV: begin
            res     = {16'(rem), 16'(quo)};
            res_dbl = 1'b1;
            bad     = (src == 16'h0000);
          end
          exec_pkg::OP_AND: res = {16'h0000, acc & src};
          exec_pkg::OP_OR:  res = {16'h0000, acc | src};
          exec_pkg::OP_XOR: res = {16'h0000, acc ^ src};
          // masked substitute, register and short memory forms only
          exec_pkg::OP_MASK_SUB: begin
            res = {16'h0000, (acc & ~acc1) | (src & acc1)};
            bad = (core_reg.fmt == exec_pkg::FMT_IMMEDIATE) ||
                  (core_reg.fmt == exec_pkg::FMT_INDEXED);
          end
          default: bad = 1'b1;
        endcase
        if (bad) begin
          core_next.illegal = 1'b1;
        end else if (!(core_reg.op == exec_pkg::OP_ROT_ZERO && core_next.mem_we)) begin
          if (!cmp_op) begin
            rf.we[0]    = 1'b1;
            rf.wdata[0] = res_dbl ? res[31:16] : res[15:0];
            rf.we[1]    = res_dbl;
            rf.wdata[1] = res[15:0];
          end
          core_next.cc = exec_pkg::CC_RESET;
          if (cmp_op) begin
            core_next.cc[exec_pkg::CC_NONZERO_BIT]  = (res != 32'h00000000);
            core_next.cc[exec_pkg::CC_NEGATIVE_BIT] = lt;
          end else if (core_reg.op == exec_pkg::OP_DIV) begin
            core_next.cc[exec_pkg::CC_NONZERO_BIT]  = (res[15:0] != 16'h0000);
            core_next.cc[exec_pkg::CC_NEGATIVE_BIT] = res[15];
          end else begin
            core_next.cc[exec_pkg::CC_NONZERO_BIT]  = res_dbl ? (res != 32'h00000000) :
                                                        (res[15:0] != 16'h0000);
            core_next.cc[exec_pkg::CC_NEGATIVE_BIT] = res_dbl ? res[31] : res[15];
          end
        end
      end
      default: core_next.st = exec_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      core_reg    <= '0;
      core_reg.st <= exec_pkg::ST_IDLE;
      core_reg.cc <= exec_pkg::CC_RESET;
    end else begin
      core_reg <= core_next;
    end
  end

  assign peek_data      = rf.rdata[exec_pkg::RP_ACC];
  assign done           = core_reg.done;
  assign illegal        = core_reg.illegal;
  assign mem_write_en   = core_reg.mem_we;
  assign mem_write_data = core_reg.mem_wdata;
  assign cond_code      = core_reg.cc;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_rotate_by_one: assert property (
    is_exec && core_reg.op == exec_pkg::OP_ROT_ZERO && core_reg.fmt == exec_pkg::FMT_IMMEDIATE
    && core_reg.y[5:0] == 6'h01 |-> rf.wdata[0] == {acc[14:0], acc1[15]}
    && rf.wdata[1] == {acc1[14:0], acc[15]}) else $error("pair rotate by one wrong");
  a_zero_store_word: assert property (
    is_exec && core_reg.op == exec_pkg::OP_ROT_ZERO && core_reg.fmt == exec_pkg::FMT_INDEXED
    |=> mem_write_en && mem_write_data == 16'h0000 && done) else $error("store zeros missing");
  a_sub_single_result: assert property (
    is_exec && core_reg.op == exec_pkg::OP_SUB |-> rf.we[0] && !rf.we[1]
    && 16'(rf.wdata[0] + src) == acc) else $error("subtract result wrong");
  a_dbl_imm_illegal: assert property (
    is_exec && core_reg.op == exec_pkg::OP_SUB_DBL && core_reg.fmt == exec_pkg::FMT_IMMEDIATE
    |-> rf.we == 2'h0 ##1 illegal) else $error("double immediate not refused");
  a_add_double_sum: assert property (
    is_exec && core_reg.op == exec_pkg::OP_ADD_DBL && !bad |-> rf.we == 2'h3
    && 32'({rf.wdata[0], rf.wdata[1]} - src_dbl) == acc_dbl) else $error("double add wrong");
  a_cmp_no_write: assert property (
    is_exec && (core_reg.op == exec_pkg::OP_CMP || core_reg.op == exec_pkg::OP_CMP_DBL)
    |-> rf.we == 2'h0 ##1 !mem_write_en) else $error("compare touched a register");
  a_mul_pair_product: assert property (
    is_exec && core_reg.op == exec_pkg::OP_MUL |-> {rf.wdata[0], rf.wdata[1]} ==
    32'($signed(src)) * 32'($signed(acc1))) else $error("multiply product wrong");
  a_div_rem_sign: assert property (
    is_exec && core_reg.op == exec_pkg::OP_DIV && !bad && rf.wdata[0] != 16'h0000
    |-> rf.wdata[0][15] == acc[15]) else $error("remainder sign differs from dividend");
  a_mask_sub_bits: assert property (
    is_exec && core_reg.op == exec_pkg::OP_MASK_SUB && !bad |-> rf.wdata[0] ==
    ((acc & ~acc1) | (src & acc1))) else $error("masked substitute wrong");
  a_cc_nonzero_bit: assert property (
    is_exec && core_reg.op == exec_pkg::OP_ADD |=> cond_code[exec_pkg::CC_NONZERO_BIT] ==
    ($past(res[15:0]) != 16'h0000) && cond_code[exec_pkg::CC_NEGATIVE_BIT] == $past(res[15]))
    else $error("condition code after add wrong");
  a_illegal_keeps_cc: assert property (
    is_exec && bad |-> rf.we == 2'h0 ##1 illegal && done && !mem_write_en && $stable(cond_code))
    else $error("illegal instruction changed state");
endmodule

// ===== verification/mem_model.sv
// memory partner: returns the words at Y and Y+1 and takes the unit's writes
// assumes the bench holds operand_y steady from start until after done
`timescale 1ns/10ps
module mem_model (
  // clock
  input  wire logic        core_clk,
  // from the bench and the unit
  input  wire logic [15:0] operand_y,
  input  wire logic        mem_write_en,
  input  wire logic [15:0] mem_write_data,
  // to the unit
  output logic      [15:0] mem_word_y,
  output logic      [15:0] mem_word_y1
);
  logic [15:0] mem [16];

  initial begin
    for (int i = 0; i < 16; i++) begin
      mem[i] = 16'h0101 * 16'(i);
    end
  end

  assign mem_word_y  = mem[operand_y[3:0]];
  assign mem_word_y1 = mem[operand_y[3:0] + 4'h1];

  always @(posedge core_clk) begin
    if (mem_write_en) begin
      mem[operand_y[3:0]] <= mem_write_data;
    end
  end
endmodule

// ===== verification/arith_logic_exec_unit_test.sv
// self-checking bench for the execution datapath with a memory partner
// assumes the unit answers three cycles after start, as its hand-over says
`timescale 1ns/10ps
module arith_logic_exec_unit_test;
  logic        core_clk  = 1'b0;
  logic        rst       = 1'b1;
  logic        start     = 1'b0;
  logic [5:0]  opcode    = 6'h00;
  logic [1:0]  format    = 2'h0;
  logic [3:0]  acc_sel   = 4'h0;
  logic [3:0]  src_sel   = 4'h0;
  logic [15:0] operand_y = 16'h0000;
  logic        load_en   = 1'b0;
  logic [3:0]  load_sel  = 4'h0;
  logic [15:0] load_data = 16'h0000;
  logic [3:0]  peek_sel  = 4'h0;
  logic [15:0] mem_word_y;
  logic [15:0] mem_word_y1;
  logic [15:0] peek_data;
  logic        done;
  logic        illegal;
  logic        mem_write_en;
  logic [15:0] mem_write_data;
  logic [15:0] cond_code;
  logic        wr_seen;
  int          failures = 0;
  int          checked  = 0;

  always #50 core_clk = ~core_clk;

  arith_logic_exec_unit uut (
    .core_clk(core_clk), .rst(rst), .start(start), .opcode(opcode), .format(format),
    .acc_sel(acc_sel), .src_sel(src_sel), .operand_y(operand_y),
    .mem_word_y(mem_word_y), .mem_word_y1(mem_word_y1), .load_en(load_en),
    .load_sel(load_sel), .load_data(load_data), .peek_sel(peek_sel),
    .peek_data(peek_data), .done(done), .illegal(illegal),
    .mem_write_en(mem_write_en), .mem_write_data(mem_write_data), .cond_code(cond_code)
  );

  mem_model pmem (
    .core_clk(core_clk), .operand_y(operand_y), .mem_write_en(mem_write_en),
    .mem_write_data(mem_write_data), .mem_word_y(mem_word_y), .mem_word_y1(mem_word_y1)
  );

  task automatic end_of_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic step;
    @(posedge core_clk);
    #1;
  endtask

  // a spare cycle after each load keeps load_en from being set twice in one step
  task automatic load(input logic [3:0] sel, input logic [15:0] data);
    load_en   = 1'b1;
    load_sel  = sel;
    load_data = data;
    step();
    load_en = 1'b0;
    step();
  endtask

  task automatic peek(input logic [3:0] sel, input logic [15:0] exp, input string what);
    peek_sel = sel;
    repeat (2) step();
    chk(what, exp, peek_data);
  endtask

  task automatic exec(input logic [5:0] op, input logic [1:0] fmt, input logic [3:0] a,
                      input logic [3:0] m, input logic [15:0] y, input logic [15:0] cc,
                      input logic ill);
    int n;
    opcode    = op;
    format    = fmt;
    acc_sel   = a;
    src_sel   = m;
    operand_y = y;
    start     = 1'b1;
    step();
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 10) begin
      step();
      n++;
    end
    chk("latency", 16'h0002, 16'(n));
    chk("illegal", {15'h0000, ill}, {15'h0000, illegal});
    chk("cond_code", cc, cond_code);
    wr_seen = mem_write_en;
    if (n >= 10) begin
      end_of_test();
    end
  endtask

  task automatic t_rotate;
    load(4'h2, 16'h8001);
    load(4'h3, 16'h1234);
    // count field is bits 0-5 only: 0xc4 gives four places
    exec(exec_pkg::OP_ROT_ZERO, 2'h2, 4'h2, 4'h0, 16'hffc4, 16'h0100, 1'b0);
    peek(4'h2, 16'h0011, "rot_high");
    peek(4'h3, 16'h2348, "rot_low");
    // a count of one moves bit 15 of the first word into bit 0 of the second
    load(4'h2, 16'h8001);
    load(4'h3, 16'h1234);
    exec(exec_pkg::OP_ROT_ZERO, 2'h2, 4'h2, 4'h0, 16'h0041, 16'h0100, 1'b0);
    peek(4'h3, 16'h2469, "rot_one_low");
    // register count 36 wraps to four places on the 32-bit pair
    load(4'h6, 16'h0024);
    exec(exec_pkg::OP_ROT_ZERO, 2'h0, 4'h2, 4'h6, 16'h0000, 16'h0100, 1'b0);
    peek(4'h2, 16'h0022, "rot_reg_high");
  endtask

  task automatic t_store_zero;
    exec(exec_pkg::OP_ROT_ZERO, 2'h3, 4'h2, 4'h0, 16'h0005, 16'h0100, 1'b0);
    chk("zero_wr_en", 16'h0001, {15'h0000, wr_seen});
    chk("zero_data", 16'h0000, mem_write_data);
    step();
    chk("zero_mem", 16'h0000, pmem.mem[5]);
    exec(exec_pkg::OP_ROT_ZERO, 2'h1, 4'h2, 4'h0, 16'h0007, 16'h0100, 1'b0);
    step();
    chk("zero_mem_short", 16'h0000, pmem.mem[7]);
  endtask

  task automatic t_single;
    logic [5:0]  ops [5] = '{exec_pkg::OP_SUB, exec_pkg::OP_ADD, exec_pkg::OP_AND,
                             exec_pkg::OP_OR, exec_pkg::OP_XOR};
    logic [15:0] res [5] = '{16'hf100, 16'h10e0, 16'h00f0, 16'h0ff0, 16'h0f00};
    logic [1:0]  fmt;
    pmem.mem[9] = 16'h0ff0;
    load(4'h6, 16'h0ff0);
    for (int i = 0; i < 5; i++) begin
      fmt = 2'(i % 4);
      load(4'h2, 16'h00f0);
      exec(ops[i], fmt, 4'h2, 4'h6, (fmt == 2'h2) ? 16'h0ff0 : 16'h0009,
           res[i][15] ? 16'h0300 : 16'h0100, 1'b0);
      peek(4'h2, res[i], "single");
    end
  endtask

  task automatic t_double;
    logic [5:0] ops [3] = '{exec_pkg::OP_SUB_DBL, exec_pkg::OP_ADD_DBL, exec_pkg::OP_CMP_DBL};
    pmem.mem[9]  = 16'h0000;
    pmem.mem[10] = 16'h0001;
    load(4'h2, 16'h0001);
    load(4'h3, 16'hffff);
    exec(exec_pkg::OP_ADD_DBL, 2'h1, 4'h2, 4'h0, 16'h0009, 16'h0100, 1'b0);
    peek(4'h2, 16'h0002, "add_dbl_high");
    load(4'h6, 16'h0003);
    load(4'h7, 16'h0000);
    exec(exec_pkg::OP_SUB_DBL, 2'h0, 4'h2, 4'h6, 16'h0000, 16'h0300, 1'b0);
    peek(4'h3, 16'h0000, "sub_dbl_low");
    exec(exec_pkg::OP_CMP_DBL, 2'h3, 4'h2, 4'h0, 16'h0009, 16'h0300, 1'b0);
    for (int i = 0; i < 3; i++) begin
      exec(ops[i], 2'h2, 4'h2, 4'h6, 16'h0001, 16'h0300, 1'b1);
    end
    peek(4'h2, 16'hffff, "dbl_kept");
  endtask

  task automatic t_compare;
    exec(exec_pkg::OP_CMP, 2'h2, 4'h2, 4'h0, 16'hffff, 16'h0000, 1'b0);
    exec(exec_pkg::OP_CMP, 2'h2, 4'h2, 4'h0, 16'h0001, 16'h0300, 1'b0);
    exec(exec_pkg::OP_CMP, 2'h2, 4'h2, 4'h0, 16'h8000, 16'h0100, 1'b0);
    peek(4'h2, 16'hffff, "cmp_kept");
  endtask

  task automatic t_mul_div;
    // a product wider than one word must keep its upper half
    load(4'h3, 16'h0200);
    exec(exec_pkg::OP_MUL, 2'h2, 4'h2, 4'h0, 16'h0300, 16'h0100, 1'b0);
    peek(4'h2, 16'h0006, "mul_wide_high");
    load(4'h3, 16'h0003);
    exec(exec_pkg::OP_MUL, 2'h2, 4'h2, 4'h0, 16'hffff, 16'h0300, 1'b0);
    peek(4'h2, 16'hffff, "mul_high");
    peek(4'h3, 16'hfffd, "mul_low");
    load(4'h3, 16'hfff9);
    exec(exec_pkg::OP_DIV, 2'h2, 4'h2, 4'h0, 16'h0002, 16'h0300, 1'b0);
    peek(4'h3, 16'hfffd, "quotient");
    peek(4'h2, 16'hffff, "remainder");
    exec(exec_pkg::OP_DIV, 2'h2, 4'h2, 4'h0, 16'h0000, 16'h0300, 1'b1);
    peek(4'h3, 16'hfffd, "div_zero_kept");
  endtask

  task automatic t_mask_illegal;
    load(4'h2, 16'h1234);
    load(4'h3, 16'h00ff);
    load(4'h6, 16'habcd);
    exec(exec_pkg::OP_MASK_SUB, 2'h0, 4'h2, 4'h6, 16'h0000, 16'h0100, 1'b0);
    peek(4'h2, 16'h12cd, "mask_sub");
    exec(exec_pkg::OP_MASK_SUB, 2'h2, 4'h2, 4'h6, 16'h0000, 16'h0100, 1'b1);
    exec(6'h3f, 2'h3, 4'h2, 4'h6, 16'h0005, 16'h0100, 1'b1);
    chk("illegal_wr", 16'h0000, {15'h0000, wr_seen});
    peek(4'h2, 16'h12cd, "illegal_kept");
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    #1;
    rst = 1'b0;
    step();
    chk("cc_reset", 16'h0000, cond_code);
    t_rotate();
    t_store_zero();
    t_single();
    t_double();
    t_compare();
    t_mul_div();
    t_mask_illegal();
    end_of_test();
  end
endmodule
